/* eib_pkg.sv */
// Constants shared by the program memory and port bus interface.
// Contract
// - Latch address, selects, qualifier while strobe high.
// - Program memory of 2048 eight-bit locations.
// - Memory access needs both chip selects active.
// - Read sources port if qualifier high, else memory.
// - Drive bus on read; float when strobes high.
// - Port write loads selected port, ignores qualifier.
// - Address bit zero picks first or second port.
// - High address bits affect memory only.
// - Wait low on selected strobe until clock edge.
// - Two general purpose eight-line ports.
// - Each line's direction set by own bit.
// - Reset clears both direction registers.
// - Port read strobe acts as qualified read.
// - Two low bits select port or direction register.
// - Direction bit one means output, zero input.
// - Pin level changes when write strobe returns high.
// - Output latches accept writes while drivers disabled.
package eib_pkg;
    localparam int            EIB_DATA_W   = 8;
    localparam int            EIB_ADDR_W   = 11;
    localparam int            EIB_MEM_SIZE = 2048;
    localparam int            EIB_HI_W     = 3;
    localparam logic [1:0]    EIB_SEL_PA   = 2'h0;
    localparam logic [1:0]    EIB_SEL_PB   = 2'h1;
    localparam logic [1:0]    EIB_SEL_DA   = 2'h2;
    localparam logic [1:0]    EIB_SEL_DB   = 2'h3;
    localparam logic [7:0]    EIB_DIR_RST  = 8'h00;
    localparam logic [7:0]    EIB_LAT_RST  = 8'h00;
    localparam logic [7:0]    EIB_MEM_FILL = 8'hFF;
endpackage

/* eib_sync.sv */
// Two flip-flop synchroniser for a vector of pin inputs.
`timescale 1ns/1ps
module eib_sync #(
    parameter int W = 8
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    // First stage; read only by the second stage.
    logic [W-1:0] meta;

    // Both stages reset to zero so the outputs are defined at start.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= '0;
            o_q  <= '0;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end
endmodule

/* eib_top.sv */
// Bus side of the program memory and dual port chip.
`timescale 1ns/1ps
module eib_top
    import eib_pkg::*;
(
    input  wire logic                       i_mclk,
    input  wire logic                       i_rst_n,
    input  wire logic                       i_reset_hi,
    input  wire logic                       i_addr_latch_en,
    input  wire logic                       i_io_mem_sel,
    input  wire logic [eib_pkg::EIB_HI_W-1:0] i_high_addr_bits,
    input  wire logic                       i_chip_select_low_n,
    input  wire logic                       i_chip_select_high,
    input  wire logic                       i_read_n,
    input  wire logic                       i_port_read_strobe_n,
    input  wire logic                       i_port_write_strobe_n,
    input  wire logic [eib_pkg::EIB_DATA_W-1:0] i_muxed_addr_data_bus,
    output logic      [eib_pkg::EIB_DATA_W-1:0] o_muxed_addr_data_bus,
    output logic                            o_bus_oe_n,
    output logic                            o_ready,
    output logic                            o_ready_oe_n,
    input  wire logic [eib_pkg::EIB_DATA_W-1:0] i_first_port_lines,
    output logic      [eib_pkg::EIB_DATA_W-1:0] o_first_port_lines,
    output logic      [eib_pkg::EIB_DATA_W-1:0] o_first_port_oe_n,
    input  wire logic [eib_pkg::EIB_DATA_W-1:0] i_second_port_lines,
    output logic      [eib_pkg::EIB_DATA_W-1:0] o_second_port_lines,
    output logic      [eib_pkg::EIB_DATA_W-1:0] o_second_port_oe_n
);
    import eib_pkg::*;

    // Synchronised control pins, packed for one synchroniser.
    localparam int CW = 7;
    logic [CW-1:0] ctl_raw;               // Raw control pins.
    logic [CW-1:0] ctl;                   // Synchronised control pins.
    logic [EIB_DATA_W-1:0] bus_s;         // Synchronised bus byte.
    logic [EIB_HI_W-1:0]   hi_s;          // Synchronised high bits.
    logic [EIB_DATA_W-1:0] pa_s;          // Synchronised first port pins.
    logic [EIB_DATA_W-1:0] pb_s;          // Synchronised second port pins.
    logic                  wr_n_s;        // Synchronised write strobe.

    assign ctl_raw = {i_reset_hi, i_addr_latch_en, i_io_mem_sel,
                      i_chip_select_low_n, i_chip_select_high,
                      i_read_n, i_port_read_strobe_n};

    // One synchroniser instance carries every asynchronous pin input.
    // Every pin pays two cycles of latency; the processor holds its
    // strobes for several clocks, so the delay costs no bus cycles.
    eib_sync #(
        .W (CW + 1 + EIB_HI_W + 3*EIB_DATA_W)
    ) u_sync (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_d     ({ctl_raw, i_port_write_strobe_n, i_high_addr_bits,
                   i_muxed_addr_data_bus, i_first_port_lines,
                   i_second_port_lines}),
        .o_q     ({ctl, wr_n_s, hi_s, bus_s, pa_s, pb_s})
    );

    logic rst_hi, ale, iom, csl_n, csh, rd_n, ior_n;
    assign {rst_hi, ale, iom, csl_n, csh, rd_n, ior_n} = ctl;

    // Latched address state.
    logic [EIB_DATA_W-1:0] lat_lo, next_lat_lo;   // Low address byte.
    logic [EIB_HI_W-1:0]   lat_hi, next_lat_hi;   // High address bits.
    logic                  lat_iom, next_lat_iom; // Memory or port.
    logic                  lat_ce, next_lat_ce;   // Both selects active.

    // Port state.
    logic [EIB_DATA_W-1:0] pa_lat, next_pa_lat;   // First port latch.
    logic [EIB_DATA_W-1:0] pb_lat, next_pb_lat;   // Second port latch.
    logic [EIB_DATA_W-1:0] da, next_da;           // First direction.
    logic [EIB_DATA_W-1:0] db, next_db;           // Second direction.
    logic [EIB_DATA_W-1:0] pa_out, next_pa_out;   // Shown on first pins.
    logic [EIB_DATA_W-1:0] pb_out, next_pb_out;   // Shown on second pins.
    logic                  wr_d;                  // Write strobe last cycle.
    logic                  wr_pend, next_wr_pend; // Write seen, not closed.
    // Pin driver enables, registered so the pins come straight from flops.
    logic [EIB_DATA_W-1:0] pa_oe_n, next_pa_oe_n;
    logic [EIB_DATA_W-1:0] pb_oe_n, next_pb_oe_n;

    // Bus and wait outputs.
    logic [EIB_DATA_W-1:0] bus_q, next_bus_q;
    logic                  oe_n, next_oe_n;
    logic                  rdy_oe_n, next_rdy_oe_n;

    // Program memory; erased cells read as all ones.
    logic [EIB_DATA_W-1:0] mem [EIB_MEM_SIZE];
    initial begin
        for (int k = 0; k < EIB_MEM_SIZE; k++) begin
            mem[k] = EIB_MEM_FILL;
        end
    end

    // Port view: pins for input lines, latch for output lines.
    function automatic logic [EIB_DATA_W-1:0] port_view(
        input logic [EIB_DATA_W-1:0] pins,
        input logic [EIB_DATA_W-1:0] lat,
        input logic [EIB_DATA_W-1:0] dir
    );
        port_view = (lat & dir) | (pins & ~dir);
    endfunction

    // Both read strobes share one decode, so they can never disagree.
    logic sel_ok;       // Both chip selects active.
    logic rd_req;       // A port or memory read is requested.
    logic rd_port;      // The read sources a port.
    assign sel_ok  = !csl_n && csh;
    assign rd_req  = lat_ce && (!rd_n || !ior_n);
    assign rd_port = !ior_n || lat_iom;

    // Next values of the latches, ports, bus and wait line.
    always_comb begin
        next_lat_lo   = lat_lo;
        next_lat_hi   = lat_hi;
        next_lat_iom  = lat_iom;
        next_lat_ce   = lat_ce;
        next_pa_lat   = pa_lat;
        next_pb_lat   = pb_lat;
        next_da       = da;
        next_db       = db;
        next_pa_out   = pa_out;
        next_pb_out   = pb_out;
        next_wr_pend  = wr_pend;
        next_bus_q    = bus_q;
        next_oe_n     = 1'b1;
        next_rdy_oe_n = 1'b1;
        // Transparent while the strobe is high; holds once it falls.
        if (ale) begin
            next_lat_lo  = bus_s;
            next_lat_hi  = hi_s;
            next_lat_iom = iom;
            next_lat_ce  = sel_ok;
            next_rdy_oe_n = !sel_ok;
        end
        // Write: latch the byte; the qualifier plays no part.
        if (lat_ce && !wr_n_s) begin
            next_wr_pend = 1'b1;
            if (lat_lo[1:0] == EIB_SEL_PA) begin
                next_pa_lat = bus_s;
            end else if (lat_lo[1:0] == EIB_SEL_PB) begin
                next_pb_lat = bus_s;
            end else if (lat_lo[1:0] == EIB_SEL_DA) begin
                next_da = bus_s;
            end else begin
                next_db = bus_s;
            end
        end
        // Pins update only when the write strobe rises again.
        if (wr_pend && wr_n_s && !wr_d) begin
            next_pa_out  = pa_lat;
            next_pb_out  = pb_lat;
            next_wr_pend = 1'b0;
        end
        // Reads: ports ignore high bits; direction reads give zero.
        if (rd_req) begin
            next_oe_n = 1'b0;
            if (rd_port) begin
                if (lat_lo[1:0] == EIB_SEL_PA) begin
                    next_bus_q = port_view(pa_s, pa_out, da);
                end else if (lat_lo[1:0] == EIB_SEL_PB) begin
                    next_bus_q = port_view(pb_s, pb_out, db);
                end else begin
                    next_bus_q = 8'h00;
                end
            end else begin
                next_bus_q = mem[{lat_hi, lat_lo}];
            end
        end
        // High reset pin clears directions, making every line an input.
        if (rst_hi) begin
            next_da = EIB_DIR_RST;
            next_db = EIB_DIR_RST;
        end
        // Enables follow the final direction values, reset included.
        next_pa_oe_n = ~next_da;
        next_pb_oe_n = ~next_db;
    end

    // Register all state.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lat_lo   <= 8'h00;
            lat_hi   <= 3'h0;
            lat_iom  <= 1'b0;
            lat_ce   <= 1'b0;
            pa_lat   <= EIB_LAT_RST;
            pb_lat   <= EIB_LAT_RST;
            da       <= EIB_DIR_RST;
            db       <= EIB_DIR_RST;
            pa_out   <= EIB_LAT_RST;
            pb_out   <= EIB_LAT_RST;
            wr_d     <= 1'b1;
            wr_pend  <= 1'b0;
            bus_q    <= 8'h00;
            oe_n     <= 1'b1;
            rdy_oe_n <= 1'b1;
            pa_oe_n  <= ~EIB_DIR_RST;
            pb_oe_n  <= ~EIB_DIR_RST;
        end else begin
            lat_lo   <= next_lat_lo;
            lat_hi   <= next_lat_hi;
            lat_iom  <= next_lat_iom;
            lat_ce   <= next_lat_ce;
            pa_lat   <= next_pa_lat;
            pb_lat   <= next_pb_lat;
            da       <= next_da;
            db       <= next_db;
            pa_out   <= next_pa_out;
            pb_out   <= next_pb_out;
            wr_d     <= wr_n_s;
            wr_pend  <= next_wr_pend;
            bus_q    <= next_bus_q;
            oe_n     <= next_oe_n;
            rdy_oe_n <= next_rdy_oe_n;
            pa_oe_n  <= next_pa_oe_n;
            pb_oe_n  <= next_pb_oe_n;
        end
    end

    // Direction one enables the driver (enable is active low).
    assign o_first_port_lines   = pa_out;
    assign o_second_port_lines  = pb_out;
    assign o_first_port_oe_n    = pa_oe_n;
    assign o_second_port_oe_n   = pb_oe_n;
    assign o_muxed_addr_data_bus = bus_q;
    assign o_bus_oe_n           = oe_n;
    assign o_ready              = 1'b0;  // Only ever pulls low.
    assign o_ready_oe_n         = rdy_oe_n;

    // Wait drives only after a selected strobe cycle.
    a_ready_cause: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        !rdy_oe_n |-> $past(ale && sel_ok))
        else $error("Wait driven without selected strobe.");
    // Wait releases on the next edge after the strobe drops.
    a_ready_rel: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        $past(!ale) |-> rdy_oe_n)
        else $error("Wait not released.");
    // Reset pin clears directions.
    a_dir_reset: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        $past(rst_hi) |-> (da == 8'h00 && db == 8'h00))
        else $error("Directions not cleared.");
    // Bus floats when no read strobe is low.
    a_bus_float: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        $past(rd_n && ior_n) |-> oe_n)
        else $error("Bus driven with strobes high.");
    // Bus drives after a selected read.
    a_bus_drive: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        $past(rd_req) |-> !oe_n)
        else $error("Bus not driven on read.");
    // Pins stay still while write strobe is low.
    a_pin_still: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        $past(!wr_n_s) |-> $stable(pa_out) && $stable(pb_out))
        else $error("Pin changed during write.");
    // First port write lands in its latch.
    a_pa_write: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        $past(lat_ce && !wr_n_s && lat_lo[1:0] == 2'h0 && !rst_hi)
        |-> pa_lat == $past(bus_s))
        else $error("First port write lost.");
    // Output enable follows direction bits.
    a_dir_oe: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        o_first_port_oe_n == ~da && o_second_port_oe_n == ~db)
        else $error("Direction not applied.");
    // Second port write lands in its latch.
    a_pb_write: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        $past(lat_ce && !wr_n_s && lat_lo[1:0] == EIB_SEL_PB)
        |-> pb_lat == $past(bus_s))
        else $error("Second port write lost.");
    // Direction write lands in the first direction register.
    a_dir_write: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        $past(lat_ce && !wr_n_s && lat_lo[1:0] == EIB_SEL_DA && !rst_hi)
        |-> da == $past(bus_s))
        else $error("Direction write lost.");
    // Without latched selects the bus never drives.
    a_unsel_quiet: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        $past(!lat_ce) |-> oe_n)
        else $error("Bus driven while deselected.");
    // Pins take the latches one edge after the write strobe rises.
    a_pin_update: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        $past(wr_pend && wr_n_s && !wr_d)
        |-> pa_out == $past(pa_lat) && pb_out == $past(pb_lat))
        else $error("Pins not updated after write.");
    // Direction registers read back as zero.
    a_dir_read: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        $past(rd_req && rd_port && lat_lo[1]) |-> bus_q == 8'h00)
        else $error("Direction register readable.");
    // A selected strobe pulls the wait line on the next edge.
    a_wait_hold: assert property (
        @(posedge i_mclk) disable iff (!i_rst_n)
        $past(ale && sel_ok) |-> !rdy_oe_n)
        else $error("Wait not driven.");
endmodule

/* eib_cpu_model.sv */
// Processor bus model that runs address, read and write cycles.
`timescale 1ns/1ps
module eib_cpu_model (
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_bus,
    input  wire logic       i_bus_oe_n,
    input  wire logic       i_ready_oe_n,
    output logic            o_ale      = 1'b0,
    output logic            o_io_m     = 1'b0,
    output logic [2:0]      o_hi       = 3'h0,
    output logic            o_cs_low_n = 1'b1,
    output logic            o_cs_high  = 1'b0,
    output logic            o_rd_n     = 1'b1,
    output logic            o_ior_n    = 1'b1,
    output logic            o_iow_n    = 1'b1,
    output logic [7:0]      o_bus      = 8'h00
);
    // Op 0 writes, 1 reads by the general strobe, 2 by the port strobe.
    // Only the low select follows sel, so a miss keeps one select active.
    task automatic cycle(input int op, input logic io, input logic [10:0] a,
                         input logic sel, input logic [7:0] wd,
                         output logic [7:0] rd, output logic [1:0] rdy);
        @(posedge i_mclk);
        o_ale      <= 1'b1;
        o_io_m     <= io;
        o_hi       <= a[10:8];
        o_bus      <= a[7:0];
        o_cs_low_n <= ~sel;
        o_cs_high  <= 1'b1;
        repeat (4) @(posedge i_mclk);
        @(negedge i_mclk) rdy[1] = i_ready_oe_n;
        @(posedge i_mclk);
        o_ale <= 1'b0;
        repeat (5) @(posedge i_mclk);
        @(negedge i_mclk) rdy[0] = i_ready_oe_n;
        @(posedge i_mclk);
        // A released bus shows the inverse address, never a stale copy.
        o_bus   <= (op == 0) ? wd : ~a[7:0];
        o_iow_n <= (op != 0);
        o_rd_n  <= (op != 1);
        o_ior_n <= (op != 2);
        repeat (6) @(posedge i_mclk);
        @(negedge i_mclk) rd = (i_bus_oe_n === 1'b0) ? i_bus : 8'hZZ;
        @(posedge i_mclk);
        o_iow_n <= 1'b1;
        o_rd_n  <= 1'b1;
        o_ior_n <= 1'b1;
        repeat (6) @(posedge i_mclk);
        @(negedge i_mclk);
    endtask
endmodule

/* eib_top_tb_top.sv */
// Self-checking bench for the program memory and port bus interface.
`timescale 1ns/1ps
module eib_top_tb_top;
    import eib_pkg::*;
    logic       mclk = 1'b0;   // Processor clock.
    logic       rst_n = 1'b0;  // Async reset, active low.
    logic       reset_hi = 1'b0;
    logic [7:0] pa_in = 8'h00; // Levels on the first port pins.
    logic [7:0] pb_in = 8'h00; // Levels on the second port pins.
    logic       ale, io_m, csl_n, csh, rd_n, ior_n, iow_n;
    logic [2:0] hi;
    logic [7:0] bus_in, bus_out, pa_out, pa_oe_n, pb_out, pb_oe_n, rd;
    logic       bus_oe_n, ready, ready_oe_n;
    logic [1:0] rdy;           // Wait enable during and after the strobe.
    int         err_count = 0;
    int         checks = 0;
    int         cyc = 0;

    // Half period of 25 ns gives 20 MHz.
    always #25 mclk = ~mclk;

    eib_cpu_model cpu (.i_mclk(mclk), .i_bus(bus_out), .i_bus_oe_n(bus_oe_n),
        .i_ready_oe_n(ready_oe_n), .o_ale(ale), .o_io_m(io_m), .o_hi(hi),
        .o_cs_low_n(csl_n), .o_cs_high(csh), .o_rd_n(rd_n), .o_ior_n(ior_n),
        .o_iow_n(iow_n), .o_bus(bus_in));

    eib_top dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_reset_hi(reset_hi),
        .i_addr_latch_en(ale), .i_io_mem_sel(io_m), .i_high_addr_bits(hi),
        .i_chip_select_low_n(csl_n), .i_chip_select_high(csh),
        .i_read_n(rd_n), .i_port_read_strobe_n(ior_n),
        .i_port_write_strobe_n(iow_n), .i_muxed_addr_data_bus(bus_in),
        .o_muxed_addr_data_bus(bus_out), .o_bus_oe_n(bus_oe_n),
        .o_ready(ready), .o_ready_oe_n(ready_oe_n),
        .i_first_port_lines(pa_in), .o_first_port_lines(pa_out),
        .o_first_port_oe_n(pa_oe_n), .i_second_port_lines(pb_in),
        .o_second_port_lines(pb_out), .o_second_port_oe_n(pb_oe_n));

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (err_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Preload the first port while it is input, then enable its high half.
    task automatic t_port_a();
        pa_in <= 8'h33;
        cpu.cycle(0, 1'b1, 11'h500, 1'b1, 8'h5A, rd, rdy);
        cpu.cycle(1, 1'b1, 11'h700, 1'b1, 8'h00, rd, rdy);
        check("pa_pins", rd, 8'h33);
        cpu.cycle(0, 1'b1, 11'h302, 1'b1, 8'hF0, rd, rdy);
        check("pa_oe_n", pa_oe_n, 8'h0F);
        check("pa_lat", pa_out, 8'h5A);
        cpu.cycle(1, 1'b1, 11'h000, 1'b1, 8'h00, rd, rdy);
        check("pa_mix", rd, 8'h53);
        check("pb_oe_n", pb_oe_n, 8'hFF);
    endtask

    // Second port written with the qualifier low, read by the port strobe.
    task automatic t_port_b();
        pb_in <= 8'hA5;
        cpu.cycle(0, 1'b0, 11'h101, 1'b1, 8'hC3, rd, rdy);
        cpu.cycle(0, 1'b1, 11'h003, 1'b1, 8'hFF, rd, rdy);
        check("pb_oe_n", pb_oe_n, 8'h00);
        cpu.cycle(2, 1'b0, 11'h001, 1'b1, 8'h00, rd, rdy);
        check("pb_ior", rd, 8'hC3);
        check("pa_keep", pa_oe_n, 8'h0F);
        cpu.cycle(1, 1'b1, 11'h003, 1'b1, 8'h00, rd, rdy);
        check("dir_rd", rd, 8'h00);
    endtask

    // Top memory word, with the wait output and the bus release.
    task automatic t_mem();
        cpu.cycle(1, 1'b0, 11'h7FF, 1'b1, 8'h00, rd, rdy);
        check("mem", rd, EIB_MEM_FILL);
        check("wait", {6'h00, rdy}, 8'h01);
        check("ready", ready, 1'b0);
        check("float", bus_oe_n, 1'b1);
        cpu.cycle(1, 1'b0, 11'h7FF, 1'b0, 8'h00, rd, rdy);
        check("unsel", rd, 8'hZZ);
        check("unsel_wait", {6'h00, rdy}, 8'h03);
    endtask

    // The pins keep the old value while the write strobe is still low.
    task automatic t_glitch();
        fork
            cpu.cycle(0, 1'b1, 11'h000, 1'b1, 8'h0F, rd, rdy);
            begin
                repeat (17) @(posedge mclk);
                @(negedge mclk);
                check("pa_hold", pa_out, 8'h5A);
            end
        join
        check("pa_new", pa_out, 8'h0F);
    endtask

    // The reset pin clears both direction registers.
    task automatic t_reset_hi();
        reset_hi <= 1'b1;
        repeat (5) @(posedge mclk);
        reset_hi <= 1'b0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        check("pa_clr", pa_oe_n, 8'hFF);
        check("pb_clr", pb_oe_n, 8'hFF);
    endtask

    // A hang counts as a mismatch and ends the run.
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            err_count = err_count + 1;
            report_and_stop();
        end
    end

    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        check("rst_oe", {pa_oe_n & pb_oe_n}, 8'hFF);
        check("rst_bus", {bus_oe_n, ready_oe_n}, 8'h03);
        t_port_a();
        t_port_b();
        t_mem();
        t_glitch();
        t_reset_hi();
        report_and_stop();
    end
endmodule
